// file: hdl/fscr_regs.sv
// fscr_regs: flash security, command index, reserved and configuration register bank
// What this block does
// - load security byte from nv at reset
// - double fault on load sets all bits
// - security register read only
// - backdoor key enabled only for 10
// - unsecured only for code 10
// - backdoor unsecure forces code to 10
// - command index three bits, rest zero
// - reserved register reads zero, ignores writes
// - config has four writable bits only
// - done interrupt when enabled and flag set
// - mute hides single faults and interrupt
// - double flag on real or forced fault, mute does not hide it
// - force double flags every read, interrupts
// - forced double never updates capture
// - force single flags every unmuted read, interrupts
// - forced single never updates capture
// - done flag high when command complete
// - double fault interrupt when enabled
// assumes an avalon-mm master and an external sequencer, nv reader and ecc path
`timescale 1ns/1ps
module fscr_regs (
  // clock and reset
  input  wire logic                       i_mclk,
  input  wire logic                       i_nrst,
  // avalon-mm slave
  input  wire logic [fscr_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [31:0]                i_avs_writedata,
  input  wire logic [3:0]                 i_avs_byteenable,
  output logic [31:0]                     o_avs_readdata,
  output logic                            o_avs_waitrequest,
  output logic [1:0]                      o_avs_response,
  // nv reader for the security byte
  output logic                            o_nv_req,
  output logic [17:0]                     o_nv_addr,
  input  wire logic                       i_nv_valid,
  input  wire logic [7:0]                 i_nv_data,
  input  wire logic                       i_nv_dfault,
  // command sequencer
  input  wire logic                       i_cmd_busy,
  input  wire logic                       i_backdoor_unsec,
  output logic [fscr_pkg::CIX_W-1:0]      o_cmd_word_sel,
  // ecc datapath
  input  wire logic                       i_rd_stb,
  input  wire logic                       i_real_sgl,
  input  wire logic                       i_real_dbl,
  output logic                            o_ecc_capture,
  // security decode
  output logic                            o_key_enabled,
  output logic                            o_unsecured,
  output logic                            o_sec_loaded,
  // interrupt requests
  output logic                            o_done_irq,
  output logic                            o_fault_irq
);
  import fscr_pkg::*;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic is_pat_en(input logic [1:0] f);
    is_pat_en = (f == PAT_ENABLED);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == idx[ADDR_W-1:0]);
  endfunction

  logic [7:0]       sec_raw;
  logic [7:0]       sec_view;
  logic             sec_done;
  logic [CIX_W-1:0] cix_q;
  logic [7:0]       cfg_q;
  logic [1:0]       fie_q;
  logic             sgl_flag;
  logic             dbl_flag;
  logic             done_flag;
  logic             wr_lane0;
  logic             rd_ack_q;
  logic             unmapped;
  logic [7:0]       rd_byte;
  logic             clr_sgl;
  logic             clr_dbl;

  // ------------------------------------------------------------
  // sub-blocks
  // ------------------------------------------------------------
  fscr_sec_load u_load (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .o_nv_req    (o_nv_req),
    .o_nv_addr   (o_nv_addr),
    .i_nv_valid  (i_nv_valid),
    .i_nv_data   (i_nv_data),
    .i_nv_dfault (i_nv_dfault),
    .o_sec_q     (sec_raw),
    .o_done      (sec_done)
  );

  fscr_fault_ctl u_fault (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_rd_stb    (i_rd_stb),
    .i_real_sgl  (i_real_sgl),
    .i_real_dbl  (i_real_dbl),
    .i_mute      (cfg_q[CFG_MUTE]),
    .i_force_sgl (cfg_q[CFG_FSGL]),
    .i_force_dbl (cfg_q[CFG_FDBL]),
    .i_clr_sgl   (clr_sgl),
    .i_clr_dbl   (clr_dbl),
    .o_sgl_flag  (sgl_flag),
    .o_dbl_flag  (dbl_flag),
    .o_capture   (o_ecc_capture)
  );

  // ------------------------------------------------------------
  // security view
  // ------------------------------------------------------------
  always_comb begin
    sec_view = sec_raw;
    if (i_backdoor_unsec) begin
      sec_view[SECC_HI:SECC_LO] = PAT_ENABLED;
    end
  end

  assign o_key_enabled = is_pat_en(sec_view[BACKDOOR_KEY_ENABLE_HI:BACKDOOR_KEY_ENABLE_LO]);
  assign o_unsecured   = is_pat_en(sec_view[SECC_HI:SECC_LO]);
  assign o_sec_loaded  = sec_done;

  // ------------------------------------------------------------
  // bus write side
  // ------------------------------------------------------------
  // only byte lane 0 carries register data; other lanes are ignored
  assign wr_lane0 = i_avs_write && i_avs_byteenable[0];
  assign clr_sgl  = wr_lane0 && hit(i_avs_address, FLT_IDX) && i_avs_writedata[FLT_SGL];
  assign clr_dbl  = wr_lane0 && hit(i_avs_address, FLT_IDX) && i_avs_writedata[FLT_DBL];

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cix_q <= '0;
    end else if (wr_lane0 && hit(i_avs_address, CIX_IDX)) begin
      cix_q <= i_avs_writedata[CIX_W-1:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= RST_VAL;
    end else if (wr_lane0 && hit(i_avs_address, CFG_IDX)) begin
      cfg_q <= i_avs_writedata[7:0] & CFG_WMASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      fie_q <= 2'h0;
    end else if (wr_lane0 && hit(i_avs_address, FIE_IDX)) begin
      fie_q <= i_avs_writedata[1:0];
    end
  end

  // ------------------------------------------------------------
  // status and interrupts
  // ------------------------------------------------------------
  assign done_flag   = sec_done && !i_cmd_busy;
  assign o_done_irq  = cfg_q[CFG_DONEIE] && done_flag;
  assign o_fault_irq = (fie_q[FLT_DBL] && dbl_flag)
                     || (fie_q[FLT_SGL] && sgl_flag);
  assign o_cmd_word_sel = cix_q;

  // ------------------------------------------------------------
  // bus read side
  // ------------------------------------------------------------
  always_comb begin
    rd_byte  = 8'h00;
    unmapped = 1'b0;
    case (i_avs_address)
      SEC_IDX[ADDR_W-1:0]:  rd_byte = sec_view;
      CIX_IDX[ADDR_W-1:0]:  rd_byte = {5'h00, cix_q};
      RSV_IDX[ADDR_W-1:0]:  rd_byte = 8'h00;
      CFG_IDX[ADDR_W-1:0]:  rd_byte = cfg_q;
      FIE_IDX[ADDR_W-1:0]:  rd_byte = {6'h00, fie_q};
      STAT_IDX[ADDR_W-1:0]: rd_byte = {done_flag, 7'h00};
      FLT_IDX[ADDR_W-1:0]:  rd_byte = {6'h00, dbl_flag, sgl_flag};
      default:              unmapped = 1'b1;
    endcase
  end

  // reads take one wait state so data come from a flop
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= i_avs_read && !rd_ack_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_readdata <= 32'h0000_0000;
      o_avs_response <= 2'h0;
    end else if (i_avs_read && !rd_ack_q) begin
      o_avs_readdata <= {24'h00_0000, rd_byte};
      o_avs_response <= unmapped ? 2'h2 : 2'h0;
    end
  end

  assign o_avs_waitrequest = i_avs_read && !rd_ack_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sec_ro_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (sec_done && $stable(sec_raw) && $stable(i_backdoor_unsec)
     && i_avs_write && hit(i_avs_address, SEC_IDX)) |=> $stable(sec_view))
    else $error("security register changed by write");
  cfg_mask_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (cfg_q & ~CFG_WMASK) == 8'h00)
    else $error("unwritable config bit set");
  done_irq_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_done_irq == (cfg_q[CFG_DONEIE] && !i_cmd_busy && sec_done))
    else $error("done interrupt mismatch");
  unsec_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_backdoor_unsec |-> o_unsecured)
    else $error("backdoor unsecure not forced");
  dbl_irq_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (fie_q[FLT_DBL] && dbl_flag) |-> o_fault_irq)
    else $error("double fault interrupt missing");
  cix_wr_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_lane0 && hit(i_avs_address, CIX_IDX))
      |=> cix_q == $past(i_avs_writedata[CIX_W-1:0]))
    else $error("command index not stored");

endmodule // fscr_regs

// file: pkg/fscr_pkg.sv
// fscr_pkg: register map, field positions and reset values of the flash security/config bank
// assumes a 32-bit avalon-mm slave with word addresses (byte address = 4 * index)
package fscr_pkg;

  // ------------------------------------------------------------
  // register indices and address width
  // ------------------------------------------------------------
  localparam logic [7:0] SEC_IDX  = 8'h01;
  localparam logic [7:0] CIX_IDX  = 8'h02;
  localparam logic [7:0] RSV_IDX  = 8'h03;
  localparam logic [7:0] CFG_IDX  = 8'h04;
  localparam logic [7:0] STAT_IDX = 8'h06;
  localparam logic [7:0] FLT_IDX  = 8'h07;
  localparam logic [7:0] FIE_IDX  = 8'h05;
  localparam int         ADDR_W   = 6;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BACKDOOR_KEY_ENABLE_HI   = 7;
  localparam int BACKDOOR_KEY_ENABLE_LO   = 6;
  localparam int SECC_HI    = 1;
  localparam int SECC_LO    = 0;
  localparam int CIX_W      = 3;
  localparam int CFG_DONEIE = 7;
  localparam int CFG_MUTE   = 4;
  localparam int CFG_FDBL   = 1;
  localparam int CFG_FSGL   = 0;
  localparam int STAT_DONE  = 7;
  localparam int FLT_DBL    = 1;
  localparam int FLT_SGL    = 0;

  // ------------------------------------------------------------
  // values
  // ------------------------------------------------------------
  localparam logic [1:0]  PAT_ENABLED = 2'h2;
  localparam logic [7:0]  SEC_ALL_SET = 8'hff;
  localparam logic [7:0]  CFG_WMASK   = 8'h93;
  localparam logic [17:0] SEC_NV_ADDR = 18'h3ff0f;
  localparam logic [7:0]  RST_VAL     = 8'h00;

  typedef enum logic [1:0] {
    FSCR_LD_IDLE = 2'b00,
    FSCR_LD_REQ  = 2'b01,
    FSCR_LD_DONE = 2'b11
  } fscr_ld_type;

endpackage

// file: hdl/fscr_sec_load.sv
// fscr_sec_load: fetches the security byte from non-volatile memory after reset
// assumes the nv reader answers with one-cycle valid and a double-fault flag
`timescale 1ns/1ps
module fscr_sec_load (
  // clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_nrst,
  // nv reader
  output logic                      o_nv_req,
  output logic [17:0]               o_nv_addr,
  input  wire logic                 i_nv_valid,
  input  wire logic [7:0]           i_nv_data,
  input  wire logic                 i_nv_dfault,
  // loaded value
  output logic [7:0]                o_sec_q,
  output logic                      o_done
);
  import fscr_pkg::*;

  fscr_ld_type state_q;
  logic [7:0]  sec_q;

  // ------------------------------------------------------------
  // load sequence
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= FSCR_LD_IDLE;
    end else begin
      case (state_q)
        FSCR_LD_IDLE: state_q <= FSCR_LD_REQ;
        FSCR_LD_REQ: begin
          if (i_nv_valid) begin
            state_q <= FSCR_LD_DONE;
          end
        end
        FSCR_LD_DONE: state_q <= FSCR_LD_DONE;
        default: state_q <= FSCR_LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sec_q <= SEC_ALL_SET;
    end else if (state_q == FSCR_LD_REQ && i_nv_valid) begin
      // a bad phrase leaves the part locked rather than trusting garbage
      sec_q <= i_nv_dfault ? SEC_ALL_SET : i_nv_data;
    end
  end

  assign o_nv_req  = (state_q == FSCR_LD_REQ);
  assign o_nv_addr = SEC_NV_ADDR;
  assign o_sec_q   = sec_q;
  assign o_done    = (state_q == FSCR_LD_DONE);

  sec_fault_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (state_q == FSCR_LD_REQ && i_nv_valid && i_nv_dfault) |=> sec_q == SEC_ALL_SET)
    else $error("security byte not forced on double fault");
  sec_load_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (state_q == FSCR_LD_REQ && i_nv_valid && !i_nv_dfault) |=> sec_q == $past(i_nv_data))
    else $error("security byte not loaded");

endmodule // fscr_sec_load

// file: hdl/fscr_fault_ctl.sv
// fscr_fault_ctl: ecc fault flags, forced faults and capture gating for array reads
// assumes one-cycle read strobes with real fault indications from the ecc datapath
`timescale 1ns/1ps
module fscr_fault_ctl (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // array read result
  input  wire logic i_rd_stb,
  input  wire logic i_real_sgl,
  input  wire logic i_real_dbl,
  // configuration
  input  wire logic i_mute,
  input  wire logic i_force_sgl,
  input  wire logic i_force_dbl,
  // software clear, write one to clear
  input  wire logic i_clr_sgl,
  input  wire logic i_clr_dbl,
  // outputs
  output logic      o_sgl_flag,
  output logic      o_dbl_flag,
  output logic      o_capture
);
  import fscr_pkg::*;

  logic sgl_q;
  logic dbl_q;
  logic set_sgl;
  logic set_dbl;

  // ------------------------------------------------------------
  // flag set terms
  // ------------------------------------------------------------
  assign set_dbl = i_rd_stb && (i_real_dbl || i_force_dbl);
  assign set_sgl = i_rd_stb && !i_mute && (i_real_sgl || i_force_sgl);

  // set wins over a simultaneous clear
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      dbl_q <= 1'b0;
    end else if (set_dbl) begin
      dbl_q <= 1'b1;
    end else if (i_clr_dbl) begin
      dbl_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sgl_q <= 1'b0;
    end else if (set_sgl) begin
      sgl_q <= 1'b1;
    end else if (i_clr_sgl) begin
      sgl_q <= 1'b0;
    end
  end

  // capture only on genuine faults, forced ones never overwrite
  assign o_capture  = i_rd_stb && (i_real_dbl || (i_real_sgl && !i_mute));
  assign o_sgl_flag = sgl_q;
  assign o_dbl_flag = dbl_q;

  dbl_force_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_rd_stb && i_force_dbl) |=> dbl_q)
    else $error("forced double fault not flagged");
  dbl_mute_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_rd_stb && i_real_dbl && i_mute) |=> dbl_q)
    else $error("mute blocked double fault");
  sgl_mute_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_mute && !sgl_q) |=> !sgl_q)
    else $error("single fault reported while muted");
  dbl_clean_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (!dbl_q && !(i_rd_stb && (i_real_dbl || i_force_dbl))) |=> !dbl_q)
    else $error("double fault flag without cause");
  cap_gate_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_rd_stb && !i_real_dbl && !i_real_sgl) |-> !o_capture)
    else $error("capture on forced fault");
  sgl_force_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_rd_stb && i_force_sgl && !i_mute) |=> sgl_q)
    else $error("forced single fault not flagged");

endmodule // fscr_fault_ctl

// file: dv/fscr_nv_model.sv
// fscr_nv_model: behavioural non-volatile reader that answers the security byte fetch
// assumes one request level per load and a tb-chosen answer delay of at least one cycle
`timescale 1ns/1ps
module fscr_nv_model (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // request from the bank
  input  wire logic        i_req,
  input  wire logic [17:0] i_addr,
  // stored contents and answer timing
  input  wire logic [7:0]  i_byte,
  input  wire logic        i_dfault,
  input  wire logic [3:0]  i_delay,
  // answer
  output logic             o_valid,
  output logic [7:0]       o_data,
  output logic             o_dfault
);
  import fscr_pkg::*;
  logic [3:0] cnt_q;
  logic       sent_q;
  // ------------------------------------------------------------
  // answer path
  // ------------------------------------------------------------
  // data outside the valid cycle is inverted every cycle, so a sample taken one cycle late cannot pass
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q    <= 4'h0;
      sent_q   <= 1'b0;
      o_valid  <= 1'b0;
      o_data   <= 8'h00;
      o_dfault <= 1'b0;
    end else if (i_req && !sent_q && cnt_q + 4'h1 >= i_delay) begin
      sent_q   <= 1'b1;
      o_valid  <= 1'b1;
      o_data   <= (i_addr == SEC_NV_ADDR) ? i_byte : ~i_byte;
      o_dfault <= i_dfault;
    end else begin
      cnt_q    <= (i_req && !sent_q) ? cnt_q + 4'h1 : 4'h0;
      o_valid  <= 1'b0;
      o_data   <= ~o_data;
      o_dfault <= ~o_dfault;
    end
  end
endmodule // fscr_nv_model

// file: dv/test_fscr_regs.sv
// test_fscr_regs: self-checking bench for the security and configuration register bank
// assumes fscr_regs, fscr_pkg and the nv model are compiled before it
`timescale 1ns/1ps
module test_fscr_regs;
  import fscr_pkg::*;
  logic              i_mclk, i_nrst, avs_read, avs_write, nv_valid, nv_dfault;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0]       avs_writedata, rdata;
  logic [1:0]        resp;
  logic [7:0]        nv_data, nv_byte;
  logic              nv_bad, cmd_busy, backdoor, rd_stb, real_sgl, real_dbl, cap;
  logic [3:0]        nv_delay;
  logic              o_avs_waitrequest, o_nv_req, o_ecc_capture, o_key_enabled, o_unsecured;
  logic              o_sec_loaded, o_done_irq, o_fault_irq;
  logic [31:0]       o_avs_readdata;
  logic [1:0]        o_avs_response;
  logic [17:0]       o_nv_addr;
  logic [CIX_W-1:0]  o_cmd_word_sel;
  int                err_total, num_checks;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  fscr_regs fscr_regs_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(4'h1), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
    .o_nv_req(o_nv_req), .o_nv_addr(o_nv_addr), .i_nv_valid(nv_valid), .i_nv_data(nv_data),
    .i_nv_dfault(nv_dfault), .i_cmd_busy(cmd_busy), .i_backdoor_unsec(backdoor),
    .o_cmd_word_sel(o_cmd_word_sel), .i_rd_stb(rd_stb), .i_real_sgl(real_sgl),
    .i_real_dbl(real_dbl), .o_ecc_capture(o_ecc_capture), .o_key_enabled(o_key_enabled),
    .o_unsecured(o_unsecured), .o_sec_loaded(o_sec_loaded), .o_done_irq(o_done_irq),
    .o_fault_irq(o_fault_irq));
  fscr_nv_model fscr_nv_model_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req(o_nv_req),
    .i_addr(o_nv_addr), .i_byte(nv_byte), .i_dfault(nv_bad), .i_delay(nv_delay),
    .o_valid(nv_valid), .o_data(nv_data), .o_dfault(nv_dfault));
  // ------------------------------------------------------------
  // clock, watchdog, helpers
  // ------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    err_total++;
    end_sim();
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until the edge that sees waitrequest low, answer taken there
  // no local limit on the wait: only the watchdog ends a hung transfer
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_mclk);
    avs_address   <= idx[ADDR_W-1:0];
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge i_mclk);
    end while (o_avs_waitrequest !== 1'b0);
    rdata = o_avs_readdata;
    resp  = o_avs_response;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic do_reset(input logic [7:0] b, input logic bad, input logic [3:0] dly);
    int n;
    nv_byte  = b;
    nv_bad   = bad;
    nv_delay = dly;
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_nrst <= 1'b1;
    n = 0;
    while (o_sec_loaded !== 1'b1 && n < 100) begin
      @(posedge i_mclk);
      n++;
    end
    chk(n < 100, 1'b1);
  endtask
  task automatic arr_read(input logic s, input logic d);
    @(posedge i_mclk);
    rd_stb   <= 1'b1;
    real_sgl <= s;
    real_dbl <= d;
    @(negedge i_mclk);
    cap = o_ecc_capture;
    @(posedge i_mclk);
    rd_stb   <= 1'b0;
    real_sgl <= 1'b0;
    real_dbl <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_sec_decode();
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      do_reset({k, 4'hf, k}, 1'b0, 4'(i + 1));
      bus(1'b0, SEC_IDX, 8'h00);
      chk(rdata, {24'h0, k, 4'hf, k});
      @(negedge i_mclk);
      chk(o_key_enabled, k == 2'b10);
      chk(o_unsecured, k == 2'b10);
    end
    bus(1'b1, SEC_IDX, 8'h00);
    bus(1'b0, SEC_IDX, 8'h00);
    chk(rdata, 32'h0000_00ff);
    backdoor <= 1'b1;
    do_reset(8'h83, 1'b0, 4'h3);
    bus(1'b0, SEC_IDX, 8'h00);
    chk(rdata[1:0], 2'b10);
    chk(o_unsecured, 1'b1);
    backdoor <= 1'b0;
    do_reset(8'hbe, 1'b1, 4'h2);
    bus(1'b0, SEC_IDX, 8'h00);
    chk(rdata, 32'h0000_00ff);
    chk({o_key_enabled, o_unsecured}, 2'b00);
  endtask
  task automatic t_plain_regs();
    bus(1'b1, CIX_IDX, 8'hff);
    bus(1'b0, CIX_IDX, 8'h00);
    chk(rdata, 32'h0000_0007);
    chk(o_cmd_word_sel, 3'h7);
    bus(1'b1, CIX_IDX, 8'h05);
    bus(1'b0, CIX_IDX, 8'h00);
    chk(rdata, 32'h0000_0005);
    bus(1'b1, RSV_IDX, 8'hff);
    bus(1'b0, RSV_IDX, 8'h00);
    chk(rdata, 32'h0);
    bus(1'b1, CFG_IDX, 8'hff);
    bus(1'b0, CFG_IDX, 8'h00);
    chk(rdata, 32'h0000_0093);
    bus(1'b1, CFG_IDX, 8'h6c);
    bus(1'b0, CFG_IDX, 8'h00);
    chk(rdata, 32'h0);
    bus(1'b0, 8'h3f, 8'h00);
    chk(resp, 2'h2);
  endtask
  task automatic t_done();
    bus(1'b1, CFG_IDX, 8'h80);
    cmd_busy <= 1'b1;
    bus(1'b0, STAT_IDX, 8'h00);
    chk(rdata[7], 1'b0);
    chk(o_done_irq, 1'b0);
    cmd_busy <= 1'b0;
    bus(1'b0, STAT_IDX, 8'h00);
    chk(rdata[7], 1'b1);
    chk(o_done_irq, 1'b1);
    bus(1'b1, CFG_IDX, 8'h00);
    @(negedge i_mclk);
    chk(o_done_irq, 1'b0);
  endtask
  // one read with given real faults and config, then flags, irq and clear
  task automatic fault_step(input logic [7:0] cfg, input logic [7:0] ie, input logic s,
                            input logic d, output logic c, output logic [1:0] f,
                            output logic irq);
    bus(1'b1, CFG_IDX, cfg);
    bus(1'b1, FIE_IDX, ie);
    arr_read(s, d);
    c = cap;
    bus(1'b0, FLT_IDX, 8'h00);
    f = rdata[1:0];
    @(negedge i_mclk);
    irq = o_fault_irq;
    bus(1'b1, FLT_IDX, 8'h03);
    bus(1'b1, CFG_IDX, 8'h00);
  endtask
  task automatic t_faults();
    logic c, irq;
    logic [1:0] f;
    fault_step(8'h00, 8'h03, 1'b0, 1'b0, c, f, irq);
    chk({c, f, irq}, 4'b0000);
    fault_step(8'h00, 8'h03, 1'b0, 1'b1, c, f, irq);
    chk({c, f, irq}, 4'b1101);
    fault_step(8'h12, 8'h03, 1'b0, 1'b0, c, f, irq);
    chk({c, f, irq}, 4'b0101);
    fault_step(8'h02, 8'h01, 1'b0, 1'b0, c, f, irq);
    chk({c, f, irq}, 4'b0100);
    fault_step(8'h11, 8'h03, 1'b1, 1'b0, c, f, irq);
    chk({f, irq}, 3'b000);
    fault_step(8'h01, 8'h03, 1'b0, 1'b0, c, f, irq);
    chk({c, f, irq}, 4'b0011);
    fault_step(8'h01, 8'h03, 1'b1, 1'b0, c, f, irq);
    chk({c, f, irq}, 4'b1011);
    bus(1'b0, FLT_IDX, 8'h00);
    chk(rdata, 32'h0);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    err_total = 0;
    num_checks = 0;
    i_nrst = 1'b0;
    {avs_read, avs_write, cmd_busy, backdoor, rd_stb, real_sgl, real_dbl} = 7'h0;
    avs_address = '0;
    avs_writedata = 32'h0;
    nv_byte = 8'hbe;
    nv_bad = 1'b0;
    nv_delay = 4'h1;
    t_sec_decode();
    t_plain_regs();
    t_done();
    t_faults();
    end_sim();
  end
endmodule // test_fscr_regs
